// ### verilog/ifr_regs.svh
// register offsets, field codes and reset values of the input function router
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

`define IFR_ADDR_W         8
`define IFR_OFS_ACCESS     8'h00
`define IFR_OFS_CMD_SRC    8'h04
`define IFR_OFS_MAIN_SRC   8'h08
`define IFR_OFS_ADD_SRC    8'h0C
`define IFR_OFS_FN_BASE    8'h10
`define IFR_OFS_FN_LAST    8'h30
`define IFR_OFS_RESTORE    8'h34
`define IFR_OFS_IN_LEVEL   8'h38
`define IFR_OFS_CMD_STATE  8'h3C
`define IFR_OFS_IRQ_STAT   8'h40
`define IFR_OFS_IRQ_MASK   8'h44

`define IFR_LVL_BASIC      3'h1
`define IFR_LVL_EXTENDED   3'h2
`define IFR_LVL_MAX        3'h4

`define IFR_FN_OFF         7'h00
`define IFR_FN_RUN         7'h01
`define IFR_FN_CW          7'h02
`define IFR_FN_COAST       7'h03
`define IFR_FN_RAPID       7'h04
`define IFR_FN_FAULT_ACK   7'h09
`define IFR_FN_JOG_CW      7'h0A
`define IFR_FN_JOG_CCW     7'h0B
`define IFR_FN_REVERSE     7'h0C
`define IFR_FN_POT_UP      7'h0D
`define IFR_FN_POT_UP_ALT  7'h0E
`define IFR_FN_FIXED0      7'h0F
`define IFR_FN_FIXED3      7'h12
`define IFR_FN_DC_BRAKE    7'h19
`define IFR_FN_PID         7'h1B
`define IFR_FN_EXT_FAULT   7'h1D
`define IFR_FN_ADD_OFF     7'h21
`define IFR_FN_FREE        7'h63

`define IFR_RST_ACCESS     3'h1
`define IFR_RST_CMD_FB     3'h6
`define IFR_RST_CMD_DI     3'h2
`define IFR_RST_SRC_FB     3'h6
`define IFR_RST_SRC_AN     3'h2
`define IFR_RST_ADD_SRC    3'h0
`define IFR_RST_FN_TABLE   63'h0000_4889_01E2_4601

`define IFR_IRQ_REJECT     0
`define IFR_IRQ_FAULT_ACK  1
`define IFR_IRQ_EXT_FAULT  2
`define IFR_IRQ_W          3

`endif

// ### verilog/ifr_pkg.sv
// types shared by the input function router
package ifr_pkg;

   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_POT,
      SRC_ANALOG,
      SRC_FIXED,
      SRC_SERIAL232,
      SRC_FIELDBUS
   } ifr_setpoint_src_e;

   typedef enum logic [2:0] {
      CMD_FACTORY,
      CMD_PANEL,
      CMD_INPUTS,
      CMD_SERIAL232,
      CMD_SERIAL485,
      CMD_FIELDBUS
   } ifr_cmd_src_e;

   typedef struct packed {
      logic       runRampStop;
      logic       startCw;
      logic       coastStop;
      logic       rapidRampStop;
      logic       faultAck;
      logic       jogCw;
      logic       jogCcw;
      logic       reverse;
      logic       motorizedPotUp;
      logic [3:0] fixedFreqSel;
      logic       dcBrake;
      logic       pidEnable;
      logic       extFault;
      logic       addSetpointOff;
   } ifr_cmd_s;

   typedef logic [6:0] ifr_code_t;

endpackage

// ### verilog/input_function_router.sv
// register-configured router from digital inputs to drive control commands
`timescale 1ns/100ps
`include "ifr_regs.svh"

module input_function_router #(
   parameter int         NUM_INPUTS   = 9,
   parameter logic       HAS_FIELDBUS = 1'b1
) (
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic                          clockEnable,
   input  wire logic [NUM_INPUTS-1:0]         digIn,
   output      ifr_pkg::ifr_cmd_s             cmdOut,
   output      logic [NUM_INPUTS-1:0]         freeUseOut,
   output      ifr_pkg::ifr_setpoint_src_e    mainSrcOut,
   output      ifr_pkg::ifr_setpoint_src_e    addSrcOut,
   output      ifr_pkg::ifr_cmd_src_e         cmdSrcOut,
   output      logic                          irq,
   input  wire logic [`IFR_ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output      logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output      logic                          s_axi_wready,
   output      logic [1:0]                    s_axi_bresp,
   output      logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [`IFR_ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output      logic                          s_axi_arready,
   output      logic [31:0]                   s_axi_rdata,
   output      logic [1:0]                    s_axi_rresp,
   output      logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready
);

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         CMD_W       = $bits(ifr_pkg::ifr_cmd_s);

   // register state
   logic [2:0]              accessReg;
   logic [2:0]              cmdSrcReg;
   logic [2:0]              mainSrcReg;
   logic [2:0]              addSrcReg;
   ifr_pkg::ifr_code_t      fnReg [NUM_INPUTS];
   logic [`IFR_IRQ_W-1:0]   irqStatReg;
   logic [`IFR_IRQ_W-1:0]   irqMaskReg;

   // AXI write channel holding
   logic                    awHeld;
   logic [`IFR_ADDR_W-1:0]  awAddrReg;
   logic                    wHeld;
   logic [31:0]             wDataReg;
   logic                    wLane0Reg;
   logic                    doWrite;
   logic                    wrMapped;
   logic                    wrReject;
   logic                    restoreReq;
   logic [6:0]              wrCode;
   logic [`IFR_ADDR_W-1:0]  fnOfs;
   logic [3:0]              fnIdx;
   logic                    wrFn;

   function automatic logic fnValid(input ifr_pkg::ifr_code_t c);
      case (c)
         `IFR_FN_OFF, `IFR_FN_RUN, `IFR_FN_CW, `IFR_FN_COAST, `IFR_FN_RAPID,
         `IFR_FN_FAULT_ACK, `IFR_FN_JOG_CW, `IFR_FN_JOG_CCW, `IFR_FN_REVERSE,
         `IFR_FN_POT_UP, `IFR_FN_POT_UP_ALT, `IFR_FN_DC_BRAKE, `IFR_FN_PID,
         `IFR_FN_EXT_FAULT, `IFR_FN_ADD_OFF, `IFR_FN_FREE: fnValid = 1'b1;
         default: fnValid = (c >= `IFR_FN_FIXED0) && (c <= `IFR_FN_FIXED3);
      endcase
   endfunction

   function automatic logic srcValid(input logic [6:0] c);
      srcValid = (c <= 7'h04) || (c == 7'h06);
   endfunction

   function automatic logic cmdSrcValid(input logic [6:0] c);
      cmdSrcValid = (c <= 7'h02) || (c >= 7'h04 && c <= 7'h06);
   endfunction

   function automatic ifr_pkg::ifr_code_t fnDefault(input int i);
      logic [62:0] table_v;
      table_v   = `IFR_RST_FN_TABLE;
      fnDefault = table_v[i*7 +: 7];
   endfunction

   function automatic logic fnFree(input logic [3:0] idx);
      fnFree = 1'b0;
      for (int k = 0; k < NUM_INPUTS; k++) begin
         if (idx == 4'(k) && fnReg[k] == `IFR_FN_FREE) begin
            fnFree = 1'b1;
         end
      end
   endfunction

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign wrCode  = wDataReg[6:0];
   assign fnOfs   = awAddrReg - `IFR_OFS_FN_BASE;
   assign fnIdx   = fnOfs[5:2];
   assign wrFn    = (awAddrReg >= `IFR_OFS_FN_BASE) && (awAddrReg <= `IFR_OFS_FN_LAST);

   // write decode: mapped check and refusal of illegal or locked writes
   always_comb begin
      wrMapped   = 1'b1;
      wrReject   = 1'b0;
      restoreReq = 1'b0;
      if (awAddrReg[1:0] != 2'h0) begin
         wrMapped = 1'b0;
      end else if (wrFn) begin
         wrReject = (accessReg < `IFR_LVL_EXTENDED)
                    || (fnFree(fnIdx))
                    || !fnValid(wrCode) || (wDataReg[31:7] != 25'h0);
      end else begin
         case (awAddrReg)
            `IFR_OFS_ACCESS:    wrReject = (wDataReg > 32'(`IFR_LVL_MAX));
            `IFR_OFS_CMD_SRC:   wrReject = !cmdSrcValid(wrCode) || (wDataReg[31:7] != 25'h0);
            `IFR_OFS_MAIN_SRC,
            `IFR_OFS_ADD_SRC:   wrReject = (accessReg < `IFR_LVL_BASIC)
                                           || !srcValid(wrCode) || (wDataReg[31:7] != 25'h0);
            `IFR_OFS_RESTORE:   restoreReq = wDataReg[0];
            `IFR_OFS_IRQ_STAT,
            `IFR_OFS_IRQ_MASK:  wrReject = 1'b0;
            default:            wrMapped = 1'b0;
         endcase
      end
      if (!wLane0Reg) begin
         wrReject   = 1'b1;
         restoreReq = 1'b0;
      end
   end

   // aw and w taken in either order
   always_ff @(posedge clock) begin
      if (rst) begin
         awHeld    <= 1'b0;
         awAddrReg <= '0;
      end else if (clockEnable) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld    <= 1'b1;
            awAddrReg <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wHeld     <= 1'b0;
         wDataReg  <= '0;
         wLane0Reg <= 1'b0;
      end else if (clockEnable) begin
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld     <= 1'b1;
            wDataReg  <= s_axi_wdata;
            wLane0Reg <= s_axi_wstrb[0];
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clockEnable) begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clock) begin
      if (rst || (clockEnable && doWrite && wrMapped && restoreReq)) begin
         accessReg  <= `IFR_RST_ACCESS;
         cmdSrcReg  <= HAS_FIELDBUS ? `IFR_RST_CMD_FB : `IFR_RST_CMD_DI;
         mainSrcReg <= HAS_FIELDBUS ? `IFR_RST_SRC_FB : `IFR_RST_SRC_AN;
         addSrcReg  <= `IFR_RST_ADD_SRC;
      end else if (clockEnable && doWrite && wrMapped && !wrReject) begin
         case (awAddrReg)
            `IFR_OFS_ACCESS:   accessReg  <= wDataReg[2:0];
            `IFR_OFS_CMD_SRC:  cmdSrcReg  <= wDataReg[2:0];
            `IFR_OFS_MAIN_SRC: mainSrcReg <= wDataReg[2:0];
            `IFR_OFS_ADD_SRC:  addSrcReg  <= wDataReg[2:0];
            default: ;
         endcase
      end
   end

   // per-input function selection and decode
   ifr_pkg::ifr_cmd_s      cmdVec [NUM_INPUTS];
   logic [NUM_INPUTS-1:0]  freeVec;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
         always_ff @(posedge clock) begin
            if (rst || (clockEnable && doWrite && wrMapped && restoreReq)) begin
               fnReg[gi] <= fnDefault(gi);
            end else if (clockEnable && doWrite && wrMapped && !wrReject && wrFn
                         && fnIdx == 4'(gi)) begin
               fnReg[gi] <= wrCode;
            end
         end

         always_comb begin
            ifr_pkg::ifr_code_t c;
            logic               d;
            c              = fnReg[gi];
            d              = digIn[gi];
            cmdVec[gi]     = '0;
            freeVec[gi]    = 1'b0;
            case (c)
               `IFR_FN_OFF:        ;
               `IFR_FN_RUN:        cmdVec[gi].runRampStop    = d;
               `IFR_FN_CW:         cmdVec[gi].startCw        = d;
               `IFR_FN_COAST:      cmdVec[gi].coastStop      = d;
               `IFR_FN_RAPID:      cmdVec[gi].rapidRampStop  = d;
               `IFR_FN_FAULT_ACK:  cmdVec[gi].faultAck       = d;
               `IFR_FN_JOG_CW:     cmdVec[gi].jogCw          = d;
               `IFR_FN_JOG_CCW:    cmdVec[gi].jogCcw         = d;
               `IFR_FN_REVERSE:    cmdVec[gi].reverse        = d;
               `IFR_FN_POT_UP,
               `IFR_FN_POT_UP_ALT: cmdVec[gi].motorizedPotUp = d;
               `IFR_FN_DC_BRAKE:   cmdVec[gi].dcBrake        = d;
               `IFR_FN_PID:        cmdVec[gi].pidEnable      = d;
               `IFR_FN_EXT_FAULT:  cmdVec[gi].extFault       = d;
               `IFR_FN_ADD_OFF:    cmdVec[gi].addSetpointOff = d;
               `IFR_FN_FREE:       freeVec[gi]               = d;
               default: begin
                  if (c >= `IFR_FN_FIXED0 && c <= `IFR_FN_FIXED3) begin
                     cmdVec[gi].fixedFreqSel[2'(c - `IFR_FN_FIXED0)] = d;
                  end
               end
            endcase
         end
      end
   endgenerate

   // several inputs on one command act as a wired OR
   ifr_pkg::ifr_cmd_s cmdAll;
   always_comb begin
      logic [CMD_W-1:0] acc;
      acc = '0;
      for (int k = 0; k < NUM_INPUTS; k++) begin
         acc = acc | cmdVec[k];
      end
      cmdAll = acc;
   end

   function automatic ifr_pkg::ifr_setpoint_src_e srcDecode(input logic [2:0] v);
      case (v)
         3'h1:    srcDecode = ifr_pkg::SRC_POT;
         3'h2:    srcDecode = ifr_pkg::SRC_ANALOG;
         3'h3:    srcDecode = ifr_pkg::SRC_FIXED;
         3'h4:    srcDecode = ifr_pkg::SRC_SERIAL232;
         3'h6:    srcDecode = ifr_pkg::SRC_FIELDBUS;
         default: srcDecode = ifr_pkg::SRC_NONE;
      endcase
   endfunction

   // registered outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         cmdOut     <= '0;
         freeUseOut <= '0;
         mainSrcOut <= ifr_pkg::SRC_NONE;
         addSrcOut  <= ifr_pkg::SRC_NONE;
         cmdSrcOut  <= ifr_pkg::CMD_FACTORY;
      end else if (clockEnable) begin
         cmdOut     <= cmdAll;
         freeUseOut <= freeVec;
         mainSrcOut <= srcDecode(mainSrcReg);
         addSrcOut  <= srcDecode(addSrcReg);
         case (cmdSrcReg)
            3'h1:    cmdSrcOut <= ifr_pkg::CMD_PANEL;
            3'h2:    cmdSrcOut <= ifr_pkg::CMD_INPUTS;
            3'h4:    cmdSrcOut <= ifr_pkg::CMD_SERIAL232;
            3'h5:    cmdSrcOut <= ifr_pkg::CMD_SERIAL485;
            3'h6:    cmdSrcOut <= ifr_pkg::CMD_FIELDBUS;
            default: cmdSrcOut <= ifr_pkg::CMD_FACTORY;
         endcase
      end
   end

   // interrupts
   logic [`IFR_IRQ_W-1:0] irqEvt;
   logic [`IFR_IRQ_W-1:0] irqClr;

   always_comb begin
      irqEvt = '0;
      irqEvt[`IFR_IRQ_REJECT]    = doWrite && wrMapped && wrReject;
      irqEvt[`IFR_IRQ_FAULT_ACK] = cmdAll.faultAck && !cmdOut.faultAck;
      irqEvt[`IFR_IRQ_EXT_FAULT] = cmdAll.extFault && !cmdOut.extFault;
      irqClr = '0;
      if (doWrite && wLane0Reg && awAddrReg == `IFR_OFS_IRQ_STAT) begin
         irqClr = wDataReg[`IFR_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqStatReg <= '0;
         irqMaskReg <= '0;
         irq        <= 1'b0;
      end else if (clockEnable) begin
         // a new event wins over a clear in the same cycle
         irqStatReg <= (irqStatReg & ~irqClr) | irqEvt;
         if (doWrite && wLane0Reg && awAddrReg == `IFR_OFS_IRQ_MASK) begin
            irqMaskReg <= wDataReg[`IFR_IRQ_W-1:0];
         end
         irq <= |(((irqStatReg & ~irqClr) | irqEvt) & irqMaskReg);
      end
   end

   // AXI read channel
   logic [31:0] rdMux;
   logic        rdMapped;
   logic [`IFR_ADDR_W-1:0] rdOfs;
   assign rdOfs = s_axi_araddr - `IFR_OFS_FN_BASE;

   always_comb begin
      rdMux    = 32'h0;
      rdMapped = (s_axi_araddr[1:0] == 2'h0);
      if (s_axi_araddr >= `IFR_OFS_FN_BASE && s_axi_araddr <= `IFR_OFS_FN_LAST) begin
         for (int k = 0; k < NUM_INPUTS; k++) begin
            if (rdOfs[5:2] == 4'(k)) begin
               rdMux = {25'h0, fnReg[k]};
            end
         end
      end else begin
         case (s_axi_araddr)
            `IFR_OFS_ACCESS:    rdMux = {29'h0, accessReg};
            `IFR_OFS_CMD_SRC:   rdMux = {29'h0, cmdSrcReg};
            `IFR_OFS_MAIN_SRC:  rdMux = {29'h0, mainSrcReg};
            `IFR_OFS_ADD_SRC:   rdMux = {29'h0, addSrcReg};
            `IFR_OFS_RESTORE:   rdMux = 32'h0;
            `IFR_OFS_IN_LEVEL:  rdMux = 32'(digIn);
            `IFR_OFS_CMD_STATE: rdMux = 32'(cmdOut);
            `IFR_OFS_IRQ_STAT:  rdMux = 32'(irqStatReg);
            `IFR_OFS_IRQ_MASK:  rdMux = 32'(irqMaskReg);
            default:            rdMapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clockEnable) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMapped ? rdMux : 32'h0;
            s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ### verification/ifr_monitor.sv
// port checker for the input function router, bound into the design
`timescale 1ns/100ps
module ifr_monitor #(
   parameter int   NUM_INPUTS   = 9,
   parameter logic HAS_FIELDBUS = 1'b1
) (
   input wire logic                       clock,
   input wire logic                       rst,
   input wire logic                       clockEnable,
   input wire logic [NUM_INPUTS-1:0]      digIn,
   input wire ifr_pkg::ifr_cmd_s          cmdOut,
   input wire logic [NUM_INPUTS-1:0]      freeUseOut,
   input wire ifr_pkg::ifr_setpoint_src_e mainSrcOut,
   input wire ifr_pkg::ifr_cmd_src_e      cmdSrcOut,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic [31:0]                s_axi_rdata,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready
);
   localparam ifr_pkg::ifr_setpoint_src_e DEF_MAIN =
      HAS_FIELDBUS ? ifr_pkg::SRC_FIELDBUS : ifr_pkg::SRC_ANALOG;
   localparam ifr_pkg::ifr_cmd_src_e DEF_CMD =
      HAS_FIELDBUS ? ifr_pkg::CMD_FIELDBUS : ifr_pkg::CMD_INPUTS;
   logic [1:0] sinceRst;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // enabled edges since reset, saturates
   always_ff @(posedge clock) begin
      if (rst)
         sinceRst <= 2'h0;
      else if (clockEnable && sinceRst != 2'h3)
         sinceRst <= sinceRst + 2'h1;
   end

   sequence wrBoth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clockEnable;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready && clockEnable;
   endsequence

   chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   chk_rdata_steady: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   chk_write_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   chk_write_answer: assert property (wrBoth |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (rdTaken |-> ##[1:2] s_axi_rvalid)
      else $error("read data missing");
   chk_quiet_inputs: assert property (
      clockEnable && digIn == '0 |=> cmdOut == '0 && freeUseOut == '0)
      else $error("command raised with all inputs low");
   chk_free_follows: assert property (
      clockEnable |=> (freeUseOut & ~$past(digIn)) == '0)
      else $error("free-use output without input level");
   chk_default_src: assert property (
      sinceRst == 2'h2 |-> mainSrcOut == DEF_MAIN && cmdSrcOut == DEF_CMD)
      else $error("source defaults wrong after reset");
   chk_src_codes: assert property (mainSrcOut <= ifr_pkg::SRC_FIELDBUS)
      else $error("main source outside decoded set");
endmodule

bind input_function_router ifr_monitor #(.NUM_INPUTS(NUM_INPUTS), .HAS_FIELDBUS(HAS_FIELDBUS))
   ifr_monitor_i (.clock, .rst, .clockEnable, .digIn, .cmdOut, .freeUseOut, .mainSrcOut,
   .cmdSrcOut, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ### verification/ifr_switch_model.sv
// switch bank model driving the router's digital inputs
`timescale 1ns/100ps
module ifr_switch_model (
   input  wire logic       clock,
   input  wire logic [8:0] want,
   input  wire logic       slow,
   output      logic [8:0] digIn = 9'h000
);
   logic [8:0] stage = 9'h000;

   // slow mode adds one cycle of contact delay
   always @(posedge clock) begin
      stage <= want;
      digIn <= slow ? stage : want;
   end
endmodule

// ### verification/input_function_router_tb.sv
// self-checking bench for the input function router
`timescale 1ns/100ps
`include "ifr_regs.svh"
module input_function_router_tb;
   logic                       clock = 1'b0;
   logic                       rst = 1'b1;
   logic [8:0]                 want = 9'h000;
   logic                       slow = 1'b0;
   logic [8:0]                 digIn;
   logic [8:0]                 freeUseOut;
   ifr_pkg::ifr_cmd_s          cmdOut;
   ifr_pkg::ifr_setpoint_src_e mainSrcOut;
   ifr_pkg::ifr_setpoint_src_e addSrcOut;
   ifr_pkg::ifr_cmd_src_e      cmdSrcOut;
   logic                       irq;
   logic [7:0]                 awAddr = 8'h00;
   logic [7:0]                 arAddr = 8'h00;
   logic [31:0]                wData = 32'h0;
   logic                       awValid = 1'b0;
   logic                       wValid = 1'b0;
   logic                       arValid = 1'b0;
   logic                       awReady, wReady, bValid, arReady, rValid;
   logic [1:0]                 bResp, rResp, rs;
   logic [31:0]                rData, rd;
   logic [6:0]                 fn [9];
   logic [6:0]                 codes [23];
   logic [2:0]                 lvl, mainExp, addExp, cmdExp;
   int                         num_errors = 0;
   int                         tests_run = 0;

   always #4 clock = ~clock;

   ifr_switch_model ifr_switch_model_i (.clock(clock), .want(want), .slow(slow), .digIn(digIn));
   input_function_router input_function_router_i (
      .clock(clock), .rst(rst), .clockEnable(1'b1), .digIn(digIn), .cmdOut(cmdOut),
      .freeUseOut(freeUseOut), .mainSrcOut(mainSrcOut), .addSrcOut(addSrcOut),
      .cmdSrcOut(cmdSrcOut), .irq(irq), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1));

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      do begin
         @(posedge clock);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (!bValid);
      rs = bResp;
   endtask

   task automatic rdr(input logic [7:0] a);
      arAddr <= a;
      arValid <= 1'b1;
      do begin
         @(posedge clock);
         if (arReady) arValid <= 1'b0;
      end while (!rValid);
      rd = rData;
      rs = rResp;
   endtask

   task automatic settle;
      repeat (5) @(posedge clock);
   endtask

   task automatic load_defaults;
      fn = '{7'h01, 7'h0C, 7'h09, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h00, 7'h00};
      lvl = 3'h1;
      mainExp = 3'h5;
      addExp = 3'h0;
      cmdExp = 3'h5;
   endtask

   // write a function select, track acceptance, read it back
   task automatic set_fn(input int i, input logic [6:0] c);
      logic ok;
      ok = c inside {[7'h00:7'h04], [7'h09:7'h12], 7'h19, 7'h1B, 7'h1D, 7'h21, 7'h63};
      wr(8'h10 + 8'(4 * i), {25'h0, c});
      if (lvl >= 3'h2 && fn[i] != 7'h63 && ok) fn[i] = c;
      rdr(8'h10 + 8'(4 * i));
      check(rd, {25'h0, fn[i]});
   endtask

   function automatic ifr_pkg::ifr_cmd_s exp_cmd(input logic [8:0] d);
      ifr_pkg::ifr_cmd_s c;
      c = '0;
      for (int i = 0; i < 9; i++) begin
         if (d[i]) begin
            case (fn[i])
               7'h01: c.runRampStop = 1'b1;
               7'h02: c.startCw = 1'b1;
               7'h03: c.coastStop = 1'b1;
               7'h04: c.rapidRampStop = 1'b1;
               7'h09: c.faultAck = 1'b1;
               7'h0A: c.jogCw = 1'b1;
               7'h0B: c.jogCcw = 1'b1;
               7'h0C: c.reverse = 1'b1;
               7'h0D, 7'h0E: c.motorizedPotUp = 1'b1;
               7'h0F, 7'h10, 7'h11, 7'h12: c.fixedFreqSel[fn[i] - 7'h0F] = 1'b1;
               7'h19: c.dcBrake = 1'b1;
               7'h1B: c.pidEnable = 1'b1;
               7'h1D: c.extFault = 1'b1;
               7'h21: c.addSetpointOff = 1'b1;
               default: ;
            endcase
         end
      end
      return c;
   endfunction

   initial begin
      #400000;
      num_errors++;
      tally_and_finish;
   end

   initial begin
      void'($urandom(32'h6E2452F1));
      load_defaults;
      codes = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E,
                7'h0F, 7'h10, 7'h11, 7'h12, 7'h19, 7'h1B, 7'h1D, 7'h21, 7'h05, 7'h13, 7'h1A, 7'h7F};
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      settle;
      foreach (fn[i]) begin
         rdr(8'h10 + 8'(4 * i));
         check(rd, {25'h0, fn[i]});
      end
      check(32'(mainSrcOut), 32'(ifr_pkg::SRC_FIELDBUS));
      check(32'(cmdSrcOut), 32'(ifr_pkg::CMD_FIELDBUS));
      rdr(8'h50);
      check({30'h0, rs}, 32'h2);
      wr(8'h52, 32'h1);
      check({30'h0, rs}, 32'h2);
      $display("test defaults done");
      for (int l = 0; l < 2; l++) begin
         wr(`IFR_OFS_ACCESS, 32'(l));
         for (int c = 0; c < 8; c++) begin
            wr(`IFR_OFS_MAIN_SRC, 32'(c));
            wr(`IFR_OFS_ADD_SRC, 32'(7 - c));
            wr(`IFR_OFS_CMD_SRC, 32'(c));
            if (l == 1 && c != 5 && c != 7) mainExp = (c == 6) ? 3'h5 : 3'(c);
            if (l == 1 && c != 2 && c != 0) addExp = (c == 1) ? 3'h5 : 3'(7 - c);
            if (c != 3 && c != 7) cmdExp = (c > 3) ? 3'(c - 1) : 3'(c);
            settle;
            check(32'(mainSrcOut), 32'(mainExp));
            check(32'(addSrcOut), 32'(addExp));
            check(32'(cmdSrcOut), 32'(cmdExp));
         end
      end
      $display("test sources done");
      set_fn(0, 7'h02);
      wr(`IFR_OFS_ACCESS, 32'h2);
      lvl = 3'h2;
      for (int j = 0; j < 60; j++) begin
         set_fn(j % 9, (j < 23) ? codes[j] : 7'($urandom_range(40, 0)));
         want <= 9'($urandom);
         slow <= 1'($urandom);
         settle;
         check(32'(cmdOut), 32'(exp_cmd(want)));
         check(32'(freeUseOut), 32'h0);
      end
      $display("test functions done");
      set_fn(7, 7'h63);
      want <= 9'h1FF;
      settle;
      check(32'(freeUseOut), 32'h80);
      set_fn(7, 7'h01);
      set_fn(7, 7'h63);
      wr(`IFR_OFS_MAIN_SRC, 32'h3);
      wr(`IFR_OFS_RESTORE, 32'h1);
      load_defaults;
      settle;
      check(32'(mainSrcOut), 32'(ifr_pkg::SRC_FIELDBUS));
      wr(`IFR_OFS_ACCESS, 32'h2);
      lvl = 3'h2;
      set_fn(7, 7'h0A);
      $display("test free use done");
      wr(`IFR_OFS_IRQ_STAT, 32'h7);
      wr(`IFR_OFS_IRQ_MASK, 32'h1);
      want <= 9'h000;
      set_fn(2, 7'h05);
      want <= 9'h004;
      settle;
      check(32'(irq), 32'h1);
      rdr(`IFR_OFS_IRQ_STAT);
      check(rd, 32'h3);
      wr(`IFR_OFS_IRQ_STAT, 32'h1);
      settle;
      check(32'(irq), 32'h0);
      wr(`IFR_OFS_IRQ_MASK, 32'h2);
      settle;
      check(32'(irq), 32'h1);
      wr(`IFR_OFS_IRQ_STAT, 32'h2);
      settle;
      check(32'(irq), 32'h0);
      $display("test interrupt done");
      tally_and_finish;
   end
endmodule
